/* rtl/tpmc_regs.svh */
// Purpose: timing constants of the twisted-pair MAU control block
// Assumes: core_clk at 100 MHz
// Notes:   times kept in their own unit, cycle counts derived
`ifndef TPMC_REGS_SVH
`define TPMC_REGS_SVH

`define TPMC_CLK_NS        10
`define TPMC_BT_NS         100
`define TPMC_BT_CYC        (`TPMC_BT_NS / `TPMC_CLK_NS)
`define TPMC_SQ_ON_NS      75
`define TPMC_SQ_ON_CYC     (`TPMC_SQ_ON_NS / `TPMC_CLK_NS + 1)
`define TPMC_SQ_GLITCH_NS  20
`define TPMC_QUIET_NS      500
`define TPMC_QUIET_CYC     (`TPMC_QUIET_NS / `TPMC_CLK_NS)
`define TPMC_IDL_LONG_NS   200
`define TPMC_IDL_LONG_CYC  \
    ((`TPMC_IDL_LONG_NS + `TPMC_CLK_NS - 1) / `TPMC_CLK_NS)
`define TPMC_BLANK_NS      500
`define TPMC_BLANK_CYC     (`TPMC_BLANK_NS / `TPMC_CLK_NS)
`define TPMC_COLL_HOLD_BT  7
`define TPMC_COLL_HOLD_CYC (`TPMC_COLL_HOLD_BT * `TPMC_BT_CYC)
`define TPMC_CS0_HALF_CYC  (`TPMC_BT_CYC / 2)
`define TPMC_HB_DELAY_BT   11
`define TPMC_HB_DELAY_CYC  (`TPMC_HB_DELAY_BT * `TPMC_BT_CYC)
`define TPMC_HB_LEN_BT     10
`define TPMC_HB_LEN_CYC    (`TPMC_HB_LEN_BT * `TPMC_BT_CYC)
`define TPMC_LP_NS         100
`define TPMC_LP_CYC        (`TPMC_LP_NS / `TPMC_CLK_NS)
`define TPMC_LP_MAX_NS     120
`define TPMC_LP_MAX_CYC    (`TPMC_LP_MAX_NS / `TPMC_CLK_NS)
`define TPMC_JAB_MS        50
`define TPMC_JAB_CYC       (`TPMC_JAB_MS * 1000000 / `TPMC_CLK_NS)
`define TPMC_JAB_RST_MS    500
`define TPMC_JAB_RST_CYC   (`TPMC_JAB_RST_MS * 1000000 / `TPMC_CLK_NS)
`define TPMC_LK_OPEN_US    6500
`define TPMC_LK_OPEN_CYC   (`TPMC_LK_OPEN_US * 1000 / `TPMC_CLK_NS)
`define TPMC_LK_CLOSE_MS   104
`define TPMC_LK_CLOSE_CYC  (`TPMC_LK_CLOSE_MS * 1000000 / `TPMC_CLK_NS)
`define TPMC_LP_TX_MS      16
`define TPMC_LP_TX_CYC     (`TPMC_LP_TX_MS * 1000000 / `TPMC_CLK_NS)

`endif

/* rtl/tpmc_pkg.sv */
// Purpose: types and helpers of the MAU control block
// Assumes: nothing
// Notes:   long counters are 26 bits wide
package tpmc_pkg;

    typedef logic [25:0] tpmc_cnt_t;

    typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_SEND} tpmc_hb_e;
    typedef enum logic [1:0] {LK_GOOD, LK_FAIL, LK_WAIT} tpmc_lk_e;

    function automatic tpmc_cnt_t tpmc_inc(input tpmc_cnt_t v);
        return v + 26'h1;
    endfunction : tpmc_inc

    function automatic logic [5:0] tpmc_sat6(input logic [5:0] v);
        return (v == 6'h3f) ? v : v + 6'h1;
    endfunction : tpmc_sat6

endpackage : tpmc_pkg

/* rtl/tpmc_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module tpmc_sync #(
    parameter int W = 7
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : tpmc_sync

/* rtl/tpmc_timer.sv */
// Purpose: retriggerable one-shot of fixed length
// Assumes: start is a one-cycle pulse
// Notes:   busy is high for LEN cycles after start
`timescale 1ns/100ps
module tpmc_timer #(
    parameter logic [6:0] LEN = 7'h32
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;

    assign cnt_d = start ? LEN : (busy ? cnt_q - 7'h1 : 7'h0);
    assign busy  = cnt_q != 7'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 7'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : tpmc_timer

/* rtl/tpmc_top.sv */
// Purpose: control logic of a 10 Mb/s twisted-pair MAU
// Assumes: analog slicers deliver data, energy and idle-pulse levels
// Notes:   pins pass a two-flop synchroniser; BT is ten clocks
//
// Summary of operation
// [R01] Squelch releases after transmit energy persists over 75 ns.
// [R02] While squelched, transmit input and short glitches are ignored.
// [R03] Squelch closes on an idle pulse or 500 ns of quiet input.
// [R04] TP drivers forced low on long idle, jabber, link fail, quiet tail.
// [R05] Blanking of at most 500 ns after AUI idle pulse; input ignored.
// [R06] Blanking of at most 500 ns after TP idle pulse; TP input ignored.
// [R07] Collision when both directions valid and link not failed.
// [R08] Collision drives 10 MHz square wave within 9 BT.
// [R09] Loopback switches to receive data without code violations.
// [R10] Collision ended by receive idle persists 7 BT.
// [R11] Collision ended by transmit idle stops within 9 BT.
// [R12] Frames over 50 ms are cut and CS0 presented.
// [R13] After jabber, CS0 holds 0.5 s past transmit quiet.
// [R14] Heartbeat: CS0 11 BT after transmit end, held 10 BT.
// [R15] Collision, jabber or link failure suppress the heartbeat.
// [R16] Link pulse is one high interval of about 100 ns.
// [R17] Pulse window opens 6.5 ms, closes 104 ms after last event.
// [R18] No pulse in window: link fails, indicator off, paths disabled.
// [R19] Pulse or traffic inside window restarts link timers.
// [R20] Recovery by two spaced pulses or a packet, then wait for quiet.
// [R21] Link pulses every 16 ms when transmit idle, even jabbed.
// [R22] Link checking off: no pulses sent, received ones ignored.
// [R23] Active-low strap enables link checking; high disables it.
// [R24] All timing derives from the single reference clock.
// [R25] One BT is 100 ns of reference clock.
`timescale 1ns/100ps
`include "tpmc_regs.svh"
module tpmc_top #(
    parameter int unsigned JAB_CYC    = `TPMC_JAB_CYC,
    parameter int unsigned JAB_RST    = `TPMC_JAB_RST_CYC,
    parameter int unsigned LK_OPEN    = `TPMC_LK_OPEN_CYC,
    parameter int unsigned LK_CLOSE   = `TPMC_LK_CLOSE_CYC,
    parameter int unsigned LP_TX_CYC  = `TPMC_LP_TX_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic aui_tx_pair_in,
    input  wire logic aui_tx_energy,
    input  wire logic aui_tx_idl,
    input  wire logic tp_rx_pair_in,
    input  wire logic tp_rx_energy,
    input  wire logic heartbeat_select_strap,
    input  wire logic link_check_enable_n,
    output logic      tp_tx_main_driver,
    output logic      tp_tx_predistort_driver,
    output logic      aui_rx_pair_out,
    output logic      aui_collision_pair_out,
    output logic      rx_indicator,
    output logic      jabber_indicator
);
    import tpmc_pkg::*;

    localparam logic [5:0] SQ_ON    = 6'(`TPMC_SQ_ON_CYC);  // see [R24]
    localparam logic [5:0] QUIET    = 6'(`TPMC_QUIET_CYC);
    localparam logic [5:0] IDL_LONG = 6'(`TPMC_IDL_LONG_CYC);
    localparam logic [5:0] LP_MAX   = 6'(`TPMC_LP_MAX_CYC);
    localparam logic [2:0] CS0_HALF = 3'(`TPMC_CS0_HALF_CYC);
    localparam logic [6:0] HB_DLY   = 7'(`TPMC_HB_DELAY_CYC);  // see [R25]
    localparam logic [6:0] HB_LEN   = 7'(`TPMC_HB_LEN_CYC);
    localparam logic [3:0] LP_LEN   = 4'(`TPMC_LP_CYC);

    // Synchronised pins
    logic [6:0] pin_s;
    tpmc_sync #(.W(7)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({aui_tx_pair_in, aui_tx_energy, aui_tx_idl,
                    tp_rx_pair_in, tp_rx_energy,
                    heartbeat_select_strap, link_check_enable_n}),
        .q        (pin_s)
    );

    wire tx_d    = pin_s[6];
    wire tx_en_s = pin_s[5];
    wire tx_idl  = pin_s[4];
    wire rx_d    = pin_s[3];
    wire rx_en_s = pin_s[2];
    wire hb_sel  = pin_s[1];
    wire link_en = !pin_s[0];                          // see [R23]

    logic      [5:0] sq_run_q, sq_quiet_q, idl_run_q, rx_len_q;
    logic            sq_open_q, tx_tail_q, tx_act_q, jab_q;
    tpmc_cnt_t       jab_cnt_q, lk_cnt_q, lp_cnt_q;
    logic            rx_live_q, sel_rx_q, coll_q, lk_two_q;
    logic            cs0_on_q, cs0_ph_q, hb_ok_q, rx_prev_q;
    logic      [2:0] cs0_cnt_q;
    logic      [6:0] hb_cnt_q;
    logic      [3:0] lp_len_q;
    tpmc_hb_e        hb_q;
    tpmc_lk_e        lk_q;
    logic            main_q, rxo_q, rx_ind_q;
    logic            tx_blank, rx_blank, coll_hold;

    // Squelch
    wire tx_in_en  = tx_en_s && !tx_blank;             // see [R05]
    wire sq_rel    = !sq_open_q && tx_in_en
                     && sq_run_q == SQ_ON - 6'h1;      // see [R01]
    wire sq_quiet  = !tx_en_s && sq_quiet_q == QUIET - 6'h1;
    wire sq_idl    = sq_open_q && tx_idl;
    wire idl_long  = idl_run_q >= IDL_LONG - 6'h1;
    wire tail_end  = tx_tail_q && (!tx_idl || idl_long);
    wire tx_done   = tail_end || (sq_open_q && sq_quiet);
    wire tx_act    = sq_open_q || tx_tail_q;
    wire lk_bad    = link_en && lk_q != LK_GOOD;

    // Driver force-low and data forwarding
    wire force_low = jab_q || lk_bad || idl_long
                     || (sq_open_q && sq_quiet);       // see [R04]
    wire tx_wire   = tx_act && !force_low;             // see [R02]
    wire lp_out    = lp_len_q != 4'h0;
    wire main_d    = (tx_wire && tx_d) || (lp_out && link_en);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sq_run_q   <= 6'h0;
            sq_quiet_q <= 6'h0;
            idl_run_q  <= 6'h0;
            sq_open_q  <= 1'b0;
            tx_tail_q  <= 1'b0;
            tx_act_q   <= 1'b0;
        end else begin
            sq_run_q   <= tx_in_en ? tpmc_sat6(sq_run_q) : 6'h0;
            sq_quiet_q <= tx_en_s ? 6'h0 : tpmc_sat6(sq_quiet_q);
            idl_run_q  <= tx_idl ? tpmc_sat6(idl_run_q) : 6'h0;
            sq_open_q  <= (sq_idl || sq_quiet) ? 1'b0
                          : (sq_rel ? 1'b1 : sq_open_q); // see [R03]
            tx_tail_q  <= sq_idl ? 1'b1 : (tail_end ? 1'b0 : tx_tail_q);
            tx_act_q   <= tx_act;
        end
    end

    tpmc_timer #(.LEN(7'(`TPMC_BLANK_CYC))) u_tx_blank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (tx_done),                           // see [R05]
        .busy     (tx_blank)
    );

    // Jabber watchdog
    wire jab_set = !jab_q && tx_act && jab_cnt_q == 26'(JAB_CYC - 1);
    wire jab_clr = jab_q && !tx_en_s && jab_cnt_q == 26'(JAB_RST - 1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            jab_q     <= 1'b0;
            jab_cnt_q <= 26'h0;
        end else begin
            jab_q     <= jab_set ? 1'b1 : (jab_clr ? 1'b0 : jab_q);
            if (jab_set || jab_clr) begin
                jab_cnt_q <= 26'h0;                    // see [R12]
            end else if (jab_q) begin
                jab_cnt_q <= tx_en_s ? 26'h0 : tpmc_inc(jab_cnt_q);
            end else begin
                jab_cnt_q <= tx_act ? tpmc_inc(jab_cnt_q) : 26'h0;
            end
        end
    end

    // Receive side: bursts up to LP_MAX are link pulses
    wire rx_ok     = !lk_bad;                          // see [R18]
    wire rx_act    = rx_en_s && !rx_blank;             // see [R06]
    wire rx_fall   = rx_prev_q && !rx_act;
    wire lp_rx     = rx_fall && rx_len_q <= LP_MAX
                     && link_en;                       // see [R22]
    wire frame_end = rx_fall && rx_len_q > LP_MAX;
    wire rx_live   = rx_act && rx_len_q >= LP_MAX && rx_ok;
    wire tx_loop   = tx_act && rx_ok;
    wire sel_rx_d  = (!tx_loop || rx_d == tx_d) ? rx_live
                     : sel_rx_q;                       // see [R09]
    wire rxo_d     = sel_rx_q ? (rx_live && rx_d) : (tx_loop && tx_d);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_len_q  <= 6'h0;
            rx_prev_q <= 1'b0;
            rx_live_q <= 1'b0;
            sel_rx_q  <= 1'b0;
        end else begin
            rx_len_q  <= rx_act ? tpmc_sat6(rx_len_q) : 6'h0;
            rx_prev_q <= rx_act;
            rx_live_q <= rx_live;
            sel_rx_q  <= sel_rx_d;
        end
    end

    wire rx_blank_go = rx_live_q && !rx_live;
    tpmc_timer #(.LEN(7'(`TPMC_BLANK_CYC))) u_rx_blank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (rx_blank_go),                       // see [R06]
        .busy     (rx_blank)
    );

    // Collision and CS0 wave
    wire coll     = tx_act && rx_live;                 // see [R07]
    wire coll_rx0 = coll_q && !coll && tx_act && !rx_live;
    tpmc_timer #(.LEN(7'(`TPMC_COLL_HOLD_CYC))) u_coll_hold (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (coll_rx0),                          // see [R10]
        .busy     (coll_hold)
    );
    // Ends at once when transmit went idle, see [R11]
    wire cs0_req  = coll || coll_hold || jab_q || hb_q == HB_SEND;
    wire cs0_flip = cs0_on_q && cs0_cnt_q == CS0_HALF - 3'h1;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            coll_q    <= 1'b0;
            cs0_on_q  <= 1'b0;
            cs0_ph_q  <= 1'b0;
            cs0_cnt_q <= 3'h0;
        end else begin
            coll_q    <= coll;
            cs0_on_q  <= cs0_req;
            cs0_ph_q  <= cs0_req && (!cs0_on_q || (cs0_ph_q ^ cs0_flip));
            cs0_cnt_q <= (!cs0_req || !cs0_on_q || cs0_flip) ? 3'h0
                         : cs0_cnt_q + 3'h1;           // see [R08]
        end
    end

    // Heartbeat
    wire tx_end   = tx_act_q && !tx_act;
    wire hb_go    = tx_end && hb_ok_q && hb_sel;       // see [R14]
    wire hb_bad   = coll || jab_q || lk_bad;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_q     <= HB_IDLE;
            hb_cnt_q <= 7'h0;
            hb_ok_q  <= 1'b0;
        end else begin
            hb_ok_q  <= sq_rel ? !hb_bad
                        : (hb_ok_q && !hb_bad);        // see [R15]
            hb_cnt_q <= hb_cnt_q + 7'h1;
            unique case (hb_q)
                HB_IDLE: begin
                    hb_cnt_q <= 7'h0;
                    if (hb_go) begin
                        hb_q <= HB_WAIT;
                    end
                end
                HB_WAIT: begin
                    if (hb_cnt_q == HB_DLY - 7'h1) begin
                        hb_q     <= HB_SEND;
                        hb_cnt_q <= 7'h0;
                    end
                end
                HB_SEND: begin
                    if (hb_cnt_q == HB_LEN - 7'h1) begin
                        hb_q <= HB_IDLE;
                    end
                end
            endcase
        end
    end

    // Link integrity
    wire win_open = lk_cnt_q >= 26'(LK_OPEN - 1);      // see [R17]
    wire win_end  = lk_cnt_q == 26'(LK_CLOSE - 1);
    wire lp_win   = lp_rx && win_open;
    wire both_qt  = !tx_en_s && !rx_en_s;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_q     <= LK_GOOD;
            lk_cnt_q <= 26'h0;
            lk_two_q <= 1'b0;
        end else if (!link_en) begin
            lk_q     <= LK_GOOD;
            lk_cnt_q <= 26'h0;
            lk_two_q <= 1'b0;
        end else begin
            lk_cnt_q <= tpmc_inc(lk_cnt_q);
            unique case (lk_q)
                LK_GOOD: begin
                    if (lp_win || frame_end || rx_live) begin
                        lk_cnt_q <= 26'h0;             // see [R19]
                    end else if (win_end) begin
                        lk_q     <= LK_FAIL;           // see [R18]
                        lk_cnt_q <= 26'h0;
                        lk_two_q <= 1'b0;
                    end
                end
                LK_FAIL: begin
                    if (frame_end || (lp_win && lk_two_q)) begin
                        lk_q     <= LK_WAIT;           // see [R20]
                        lk_cnt_q <= 26'h0;
                    end else if (lp_rx || win_end) begin
                        lk_cnt_q <= 26'h0;
                        lk_two_q <= lp_win;
                    end
                end
                LK_WAIT: begin
                    lk_cnt_q <= 26'h0;
                    if (both_qt) begin
                        lk_q <= LK_GOOD;
                    end
                end
            endcase
        end
    end

    // Link pulse transmitter, runs on through jabber and link fail
    wire lp_fire = lp_cnt_q == 26'(LP_TX_CYC - 1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_cnt_q <= 26'h0;
            lp_len_q <= 4'h0;
        end else begin
            lp_cnt_q <= (tx_wire || !link_en || lp_fire) ? 26'h0
                        : tpmc_inc(lp_cnt_q);          // see [R21]
            lp_len_q <= lp_fire ? LP_LEN
                        : (lp_out ? lp_len_q - 4'h1 : 4'h0); // see [R16]
        end
    end

    // Output registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_q   <= 1'b0;
            rxo_q    <= 1'b0;
            rx_ind_q <= 1'b1;
        end else begin
            main_q   <= main_d;
            rxo_q    <= rxo_d;
            rx_ind_q <= !rx_live && rx_ok;             // see [R18]
        end
    end

    assign tp_tx_main_driver       = main_q;
    assign tp_tx_predistort_driver = main_q;
    assign aui_rx_pair_out         = rxo_q;
    assign aui_collision_pair_out  = cs0_ph_q;
    assign rx_indicator            = rx_ind_q;
    assign jabber_indicator        = jab_q;            // see [R13]

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence cs0_held;
        cs0_req [*4];
    endsequence

    sequence glitch_s;
        (!sq_open_q && !tx_in_en) ##1 tx_in_en [*2] ##1 !tx_in_en;
    endsequence

    sq_release_a: assert property ( // see [R01]
        $rose(sq_open_q) |-> $past(sq_run_q) == 6'h07)
        else $error("squelch released too early");
    sq_glitch_a: assert property ( // see [R02]
        glitch_s |-> !sq_open_q && !tx_wire)
        else $error("short glitch opened squelch");
    sq_close_a: assert property ( // see [R03]
        $fell(sq_open_q) |-> $past(tx_idl) || $past(sq_quiet_q) == 6'h31)
        else $error("squelch closed without cause");
    drv_jab_a: assert property ( // see [R04]
        jab_q && !lp_out |=> !tp_tx_main_driver)
        else $error("driver active during jabber");
    tx_blank_a: assert property ( // see [R05]
        tx_done |=> (tx_blank && !sq_open_q) [*8])
        else $error("transmit blanking missing");
    rx_blank_a: assert property ( // see [R06]
        rx_blank_go |=> (rx_blank && !rx_live) [*8])
        else $error("receive blanking missing");
    coll_cs0_a: assert property ( // see [R08]
        $rose(coll) |-> ##[0:90] aui_collision_pair_out)
        else $error("collision wave late");
    cs0_duty_a: assert property ( // see [R08]
        $rose(cs0_ph_q) ##1 cs0_held |-> cs0_ph_q ##1 !cs0_ph_q)
        else $error("collision wave half period wrong");
    coll_hold_a: assert property ( // see [R10]
        coll_rx0 |=> cs0_req [*8])
        else $error("collision hold missing");
    jab_cs0_a: assert property ( // see [R12]
        $rose(jab_q) && !lp_out
            |=> !tp_tx_main_driver ##[0:9] aui_collision_pair_out)
        else $error("jabber did not cut frame");
    hb_delay_a: assert property ( // see [R14]
        $rose(hb_q == HB_SEND) |-> $past(hb_cnt_q) == 7'h6d)
        else $error("heartbeat delay wrong");
    hb_block_a: assert property ( // see [R15]
        tx_end && !hb_ok_q && hb_q == HB_IDLE |=> hb_q == HB_IDLE)
        else $error("heartbeat after failed frame");
    lk_fail_a: assert property ( // see [R18]
        link_en && lk_q == LK_FAIL |=> !rx_indicator && !rx_live_q)
        else $error("link fail not shown");
    lp_width_a: assert property ( // see [R16]
        $rose(lp_out) |-> lp_out [*8] ##1 lp_out ##1 lp_out ##1 !lp_out)
        else $error("link pulse width wrong");

endmodule : tpmc_top

/* verif/tpmc_link_partner.sv */
// Purpose: twisted-pair link partner model, link pulses and frames
// Assumes: one core_clk domain
// Notes:   idle receive data toggles, so no stale level is seen
`timescale 1ns/100ps
module tpmc_link_partner #(
    parameter int PERIOD = 200
) (
    input  wire logic core_clk,
    input  wire logic pulse_en,
    input  wire logic frame_req,
    output logic      tp_rx_energy,
    output logic      tp_rx_pair_in
);
    int   cnt_q = 0;
    logic tgl_q = 1'b0;
    always @(posedge core_clk) begin
        tgl_q <= ~tgl_q;
        cnt_q <= (pulse_en && cnt_q < PERIOD - 1) ? cnt_q + 1 : 0;
    end
    // One 100 ns high interval, then idle
    assign tp_rx_energy  = frame_req
                           || (pulse_en && cnt_q >= PERIOD - 10);
    assign tp_rx_pair_in = (tp_rx_energy && !frame_req) ? 1'b1
                           : tgl_q;
endmodule : tpmc_link_partner

/* verif/tb_top.sv */
// Purpose: self-checking bench of the MAU control block
// Assumes: shortened jabber and link counts
// Notes:   drives at rising edge, samples at falling edge
`timescale 1ns/100ps
module tb_top;
    import tpmc_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0;
    logic aui_tx_pair_in = 1'b0, aui_tx_energy = 1'b0, aui_tx_idl = 1'b0;
    logic heartbeat_select_strap = 1'b1, link_check_enable_n = 1'b1;
    logic pulse_en = 1'b0, frame_req = 1'b0;
    logic tp_rx_pair_in, tp_rx_energy, drv, pre, rx_out, coll, rx_ind, jab;
    int   err_total = 0, compares = 0, n;

    always #5 core_clk = ~core_clk;

    tpmc_top #(.JAB_CYC(400), .JAB_RST(600), .LK_OPEN(100),
               .LK_CLOSE(1600), .LP_TX_CYC(300)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .aui_tx_pair_in(aui_tx_pair_in), .aui_tx_energy(aui_tx_energy),
        .aui_tx_idl(aui_tx_idl), .tp_rx_pair_in(tp_rx_pair_in),
        .tp_rx_energy(tp_rx_energy),
        .heartbeat_select_strap(heartbeat_select_strap),
        .link_check_enable_n(link_check_enable_n),
        .tp_tx_main_driver(drv), .tp_tx_predistort_driver(pre),
        .aui_rx_pair_out(rx_out), .aui_collision_pair_out(coll),
        .rx_indicator(rx_ind), .jabber_indicator(jab));

    tpmc_link_partner u_partner (
        .core_clk(core_clk), .pulse_en(pulse_en), .frame_req(frame_req),
        .tp_rx_energy(tp_rx_energy), .tp_rx_pair_in(tp_rx_pair_in));

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(int k);
        repeat (k) @(posedge core_clk);
    endtask : tick

    // Cycles until s reaches v, bounded by lim
    task automatic wait_for(ref logic s, input logic v, input int lim,
                            output int k);
        k = 0;
        while (s !== v && k < lim) begin
            @(negedge core_clk);
            k++;
        end
    endtask : wait_for

    // High cycles (or rising edges) of s over k cycles
    task automatic count(ref logic s, input int k, input bit rises,
                         output int c);
        logic p;
        c = 0;
        p = s;
        repeat (k) begin
            @(negedge core_clk);
            if (rises ? (s === 1'b1 && p !== 1'b1) : (s === 1'b1)) c++;
            p = s;
        end
    endtask : count

    task automatic t_squelch;
        @(negedge core_clk);
        chk("rx_indicator reset", rx_ind, 1);
        chk("collision reset", coll, 0);
        tick(1);
        aui_tx_energy  <= 1'b1;
        aui_tx_pair_in <= 1'b1;
        tick(5);
        aui_tx_energy  <= 1'b0;
        tick(1);
        aui_tx_energy  <= 1'b1;
        tick(2);
        aui_tx_energy  <= 1'b0;
        count(drv, 30, 0, n);
        chk("short burst forwarded", n, 0);
        tick(60);
        $display("test squelch done");
    endtask : t_squelch

    task automatic t_frame;
        tick(1);
        aui_tx_energy  <= 1'b1;
        aui_tx_pair_in <= 1'b1;
        tick(16);
        @(negedge core_clk);
        chk("driver high", drv, 1);
        chk("predistort mirrors", pre, 1);
        chk("loopback high", rx_out, 1);
        tick(1);
        aui_tx_pair_in <= 1'b0;
        tick(6);
        @(negedge core_clk);
        chk("driver low", drv, 0);
        chk("loopback low", rx_out, 0);
        tick(1);
        aui_tx_energy <= 1'b0;
        aui_tx_idl    <= 1'b1;
        tick(5);
        aui_tx_idl    <= 1'b0;
        wait_for(coll, 1'b1, 250, n);
        chk("heartbeat delay ok", n >= 55 && n <= 200, 1);
        count(coll, 150, 0, n);
        chk("heartbeat length ok", n >= 35 && n <= 75, 1);
        tick(100);
        heartbeat_select_strap <= 1'b0;
        aui_tx_energy          <= 1'b1;
        tick(20);
        aui_tx_energy <= 1'b0;
        count(coll, 300, 0, n);
        chk("heartbeat deselected", n, 0);
        tick(1);
        heartbeat_select_strap <= 1'b1;
        $display("test frame done");
    endtask : t_frame

    task automatic t_collision;
        tick(1);
        aui_tx_energy  <= 1'b1;
        aui_tx_pair_in <= 1'b1;
        frame_req      <= 1'b1;
        wait_for(coll, 1'b1, 110, n);
        chk("collision start", n < 110, 1);
        count(coll, 100, 1, n);
        chk("cs0 rate", n >= 9 && n <= 11, 1);
        count(rx_out, 20, 1, n);
        chk("loopback from receive", n, 10);
        tick(1);
        frame_req <= 1'b0;
        tick(40);
        count(coll, 20, 1, n);
        chk("collision held", n >= 1, 1);
        tick(40);
        count(coll, 20, 0, n);
        chk("collision hold ended", n, 0);
        tick(1);
        aui_tx_energy <= 1'b0;
        count(coll, 300, 0, n);
        chk("heartbeat suppressed", n, 0);
        $display("test collision done");
    endtask : t_collision

    task automatic t_jabber;
        tick(1);
        aui_tx_energy <= 1'b1;
        tick(450);
        @(negedge core_clk);
        chk("jabber set", jab, 1);
        chk("driver forced low", drv, 0);
        count(coll, 20, 0, n);
        chk("cs0 in jabber", n > 0, 1);
        tick(1);
        aui_tx_energy <= 1'b0;
        tick(300);
        @(negedge core_clk);
        chk("jabber held", jab, 1);
        tick(400);
        @(negedge core_clk);
        chk("jabber cleared", jab, 0);
        $display("test jabber done");
    endtask : t_jabber

    task automatic t_link;
        tick(1);
        link_check_enable_n <= 1'b0;
        wait_for(drv, 1'b1, 400, n);
        chk("link pulse sent", n < 400, 1);
        wait_for(drv, 1'b0, 30, n);
        chk("link pulse width", n >= 8 && n <= 12, 1);
        tick(1800);
        @(negedge core_clk);
        chk("link failed", rx_ind, 0);
        tick(1);
        pulse_en <= 1'b1;
        wait_for(rx_ind, 1'b1, 900, n);
        chk("link recovered", n < 900, 1);
        tick(1800);
        @(negedge core_clk);
        chk("link kept good", rx_ind, 1);
        $display("test link done");
    endtask : t_link

    task automatic complete_run;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial begin
        tick(20);
        rst_n <= 1'b1;
        t_squelch();
        t_frame();
        t_collision();
        t_jabber();
        t_link();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        complete_run();
    end
endmodule : tb_top
